// >>> hw/gisa_pkg.sv
// Constants and carrier types for the global interrupt source aggregator.
// Assumes an eight-channel device with a byte-wide parallel host register bus.
package gisa_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned NUM_CHAN  = 8;   // Channels served
  localparam int unsigned CODE_W    = 3;   // Bits of source code per channel
  localparam int unsigned ADDR_W    = 8;   // Host address width
  localparam int unsigned DATA_W    = 8;   // Host data width
  localparam int unsigned SYNC_W    = 11;  // Strobes plus address through the synchroniser

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] GLOBAL_BASE       = 8'h80;  // Device configuration window
  localparam logic [7:0] OFS_PENDING_MAP   = 8'h80;  // channel_pending_map
  localparam logic [7:0] OFS_CODE_LOW      = 8'h81;  // source_code_low
  localparam logic [7:0] OFS_CODE_MID      = 8'h82;  // source_code_mid
  localparam logic [7:0] OFS_CODE_HIGH     = 8'h83;  // source_code_high
  localparam logic [7:0] OFS_TIMER_COMMAND = 8'h84;  // timer_command_reg, read clears timer
  localparam logic [7:0] OFS_CH0_IDENT     = 8'h02;  // Channel 0 channel_irq_ident_reg

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0]  RESET_BYTE   = 8'h00;     // All four registers after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 11'h700; // Strobes high, address zero
  localparam logic [23:0] RESET_CODES  = 24'h00_0000;
  localparam logic [2:0]  CODE_NONE    = 3'h0;      // None or wake-up indicator
  localparam logic [2:0]  CODE_TIMER   = 3'h7;      // Timer time-out, channel 0 only

  // ************************************************************
  // Types
  // ************************************************************
  typedef logic [CODE_W-1:0] code_t;

  // Synchronised host bus sample
  typedef struct packed {
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic [7:0] addr;
  } host_bus_t;

  // Per-channel request as seen by one slot
  typedef struct packed {
    logic  req;     // Channel requests service
    logic  enable;  // Channel interrupt enable from its own enable register
    code_t code;    // Channel's own encoded source
  } chan_req_t;

  typedef enum {
    BUS_IDLE,
    BUS_READ
  } bus_state_t;

endpackage : gisa_pkg

// >>> hw/gisa_channel_slot.sv
// One channel slot: gates a channel request into a pending bit and source code.
// Assumes the request and code come from channel logic on the same clock.
`timescale 1ns/10ps
module gisa_channel_slot #(
  parameter bit IS_CHAN0 = 1'b0   // Channel 0 may carry the timer code
) (
  input  gisa_pkg::chan_req_t chanIn,
  output logic                pending,
  output gisa_pkg::code_t     code
);

  // ************************************************************
  // Gating
  // ************************************************************
  // Disabled channels and reserved codes never raise pending
  logic reservedCode;  // Timer code seen on a channel other than 0

  always_comb
  begin
    reservedCode = !IS_CHAN0 && (chanIn.code == gisa_pkg::CODE_TIMER);
    pending      = chanIn.req && chanIn.enable && !reservedCode;
    code         = pending ? chanIn.code : gisa_pkg::CODE_NONE;
  end

endmodule : gisa_channel_slot

// >>> hw/global_interrupt_source_aggregator.sv
// Global interrupt source aggregator: pending map and source locator registers.
// Assumes asynchronous host strobes on pins and channel logic on clk.
`timescale 1ns/10ps
module global_interrupt_source_aggregator (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Host parallel bus pins
  input  wire logic                 csN,
  input  wire logic                 iorN,
  input  wire logic                 iowN,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           dataIn,
  output logic      [7:0]           dataOut,
  output logic                      dataOeN,
  // Channel logic, same clock
  input  wire logic [7:0]           chanReq,
  input  wire logic [7:0]           chanIrqEnable,
  input  wire logic [23:0]          chanCode,
  // Global controls, same clock
  input  wire logic                 timerTimeout,
  input  wire logic                 timerIrqEnable,
  input  wire logic [7:0]           chanAsleep,
  input  wire logic                 wakeIrqEnable,
  // Visible state
  output logic      [7:0]           pendingMap,
  output logic      [23:0]          sourceCodes,
  output logic                      timerPending,
  output logic                      wakePending
);

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  logic [gisa_pkg::SYNC_W-1:0] syncMeta_q;  // First stage, read only by second
  logic [gisa_pkg::SYNC_W-1:0] syncMeta_d;
  logic [gisa_pkg::SYNC_W-1:0] syncOut_q;   // Second stage, safe to use
  logic [gisa_pkg::SYNC_W-1:0] syncOut_d;
  gisa_pkg::host_bus_t         bus;         // Synchronised bus view
  logic                        rdLast_q;    // Previous synchronised read strobe
  logic                        rdLast_d;

  // Next values of the two stages
  always_comb
  begin
    syncMeta_d = {csN, iorN, iowN, addr};
    syncOut_d  = syncMeta_q;
    rdLast_d   = bus.rdN;
  end

  // Strobes reset high so no phantom access after reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncMeta_q <= gisa_pkg::SYNC_IDLE;
      syncOut_q  <= gisa_pkg::SYNC_IDLE;
      rdLast_q   <= 1'b1;
    end
    else
    begin
      syncMeta_q <= syncMeta_d;
      syncOut_q  <= syncOut_d;
      rdLast_q   <= rdLast_d;
    end
  end

  assign bus = gisa_pkg::host_bus_t'(syncOut_q);

  // ************************************************************
  // Access decode
  // ************************************************************
  logic rdStart;      // One-cycle pulse at the start of a selected read
  logic rdGlobal;     // Read hits one of the four aggregate registers
  logic rdTimerCmd;   // Read of the timer command register
  logic rdCh0Ident;   // Read of channel 0 identification register

  // Address held stable by host while strobe is low, so synced copy is coherent
  always_comb
  begin
    rdStart    = rdLast_q && !bus.rdN && !bus.csN;
    rdGlobal   = 1'b0;
    rdTimerCmd = 1'b0;
    rdCh0Ident = 1'b0;
    if (bus.addr >= gisa_pkg::OFS_PENDING_MAP && bus.addr <= gisa_pkg::OFS_CODE_HIGH)
    begin
      rdGlobal = rdStart;  // No side effect on these reads
    end
    else if (bus.addr == gisa_pkg::OFS_TIMER_COMMAND)
    begin
      rdTimerCmd = rdStart;
    end
    else if (bus.addr == gisa_pkg::OFS_CH0_IDENT)
    begin
      rdCh0Ident = rdStart;
    end
    else
    begin
      rdGlobal = 1'b0;  // Other addresses belong to other blocks
    end
  end

  // ************************************************************
  // Timer and wake flags
  // ************************************************************
  logic timerFlag_q;    // Timer time-out awaiting service
  logic timerFlag_d;
  logic wakeFlag_q;     // Wake-up awaiting service
  logic wakeFlag_d;
  logic allSlept_q;     // Every channel was asleep
  logic allSlept_d;
  logic allAsleepNow;   // Every channel asleep this cycle

  // Set wins over clear so a time-out in the reading cycle is kept
  always_comb
  begin
    allAsleepNow = &chanAsleep;
    timerFlag_d  = timerFlag_q;
    if (timerTimeout && timerIrqEnable)  // Masked by timer control only
    begin
      timerFlag_d = 1'b1;
    end
    else if (rdTimerCmd)
    begin
      timerFlag_d = 1'b0;
    end
    allSlept_d = allAsleepNow ? 1'b1 : (allSlept_q && !(!allAsleepNow));
    if (!allAsleepNow)
    begin
      allSlept_d = 1'b0;  // Any waking channel ends the all-asleep span
    end
    wakeFlag_d = wakeFlag_q;
    if (allSlept_q && !allAsleepNow && wakeIrqEnable)
    begin
      wakeFlag_d = 1'b1;
    end
    else if (rdCh0Ident)
    begin
      wakeFlag_d = 1'b0;
    end
  end

  // Flags start clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timerFlag_q <= 1'b0;
      wakeFlag_q  <= 1'b0;
      allSlept_q  <= 1'b0;
    end
    else
    begin
      timerFlag_q <= timerFlag_d;
      wakeFlag_q  <= wakeFlag_d;
      allSlept_q  <= allSlept_d;
    end
  end

  // ************************************************************
  // Channel slots
  // ************************************************************
  logic [7:0]  slotPending;  // Gated pending per channel
  logic [23:0] slotCodes;    // Gated codes, channel n at 3n+2..3n

  genvar ch;
  generate
    for (ch = 0; ch < gisa_pkg::NUM_CHAN; ch++)
    begin : gSlot
      gisa_pkg::chan_req_t slotIn;  // Bundled request of this channel
      assign slotIn = '{req: chanReq[ch], enable: chanIrqEnable[ch],
                        code: chanCode[3*ch +: 3]};
      gisa_channel_slot #(
        .IS_CHAN0 (ch == 0)
      ) uSlot (
        .chanIn  (slotIn),
        .pending (slotPending[ch]),
        .code    (slotCodes[3*ch +: 3])
      );
    end
  endgenerate

  // ************************************************************
  // Aggregate registers
  // ************************************************************
  logic [7:0]  pending_q;  // channel_pending_map contents
  logic [7:0]  pending_d;
  logic [23:0] codes_q;    // source_code_high/mid/low contents
  logic [23:0] codes_d;

  // Channel 0 priority: own source, then timer, then wake with code zero
  always_comb
  begin
    pending_d = slotPending;  // Follows requests, so clears when channel clears
    codes_d   = slotCodes;
    if (!slotPending[0] && timerFlag_q)
    begin
      pending_d[0]  = 1'b1;
      codes_d[2:0]  = gisa_pkg::CODE_TIMER;
    end
    else if (!slotPending[0] && wakeFlag_q)
    begin
      pending_d[0]  = 1'b1;
      codes_d[2:0]  = gisa_pkg::CODE_NONE;
    end
    else
    begin
      pending_d[0]  = slotPending[0];
    end
  end

  // Register snapshot, zero after reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pending_q <= gisa_pkg::RESET_BYTE;
      codes_q   <= gisa_pkg::RESET_CODES;
    end
    else
    begin
      pending_q <= pending_d;
      codes_q   <= codes_d;
    end
  end

  // ************************************************************
  // Read data path
  // ************************************************************
  gisa_pkg::bus_state_t state_q;    // Bus read state
  gisa_pkg::bus_state_t state_d;
  logic [7:0]           rdData_q;   // Byte driven on the data pins
  logic [7:0]           rdData_d;

  // Capture at read start, release when strobe or select rises
  always_comb
  begin
    state_d  = state_q;
    rdData_d = rdData_q;
    case (state_q)
      gisa_pkg::BUS_IDLE:
      begin
        if (rdGlobal)
        begin
          state_d = gisa_pkg::BUS_READ;
          if (bus.addr == gisa_pkg::OFS_PENDING_MAP)
          begin
            rdData_d = pending_q;
          end
          else if (bus.addr == gisa_pkg::OFS_CODE_LOW)
          begin
            rdData_d = codes_q[7:0];
          end
          else if (bus.addr == gisa_pkg::OFS_CODE_MID)
          begin
            rdData_d = codes_q[15:8];
          end
          else
          begin
            rdData_d = codes_q[23:16];
          end
        end
      end
      gisa_pkg::BUS_READ:
      begin
        if (bus.rdN || bus.csN)
        begin
          state_d = gisa_pkg::BUS_IDLE;
        end
      end
      default:
      begin
        state_d = gisa_pkg::BUS_IDLE;
      end
    endcase
  end

  // Writes are never decoded, so they cannot alter anything
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q  <= gisa_pkg::BUS_IDLE;
      rdData_q <= gisa_pkg::RESET_BYTE;
    end
    else
    begin
      state_q  <= state_d;
      rdData_q <= rdData_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign dataOut      = rdData_q;
  assign dataOeN      = (state_q != gisa_pkg::BUS_READ);  // Low while driving
  assign pendingMap   = pending_q;
  assign sourceCodes  = codes_q;
  assign timerPending = timerFlag_q;
  assign wakePending  = wakeFlag_q;

endmodule : global_interrupt_source_aggregator

// >>> tb/gisa_host_model.sv
// Host processor model driving the parallel register bus.
// Assumes the bench calls rd and wr one at a time.
`timescale 1ns/10ps
module gisa_host_model (
  input  wire logic       clk,
  output logic            csN,
  output logic            iorN,
  output logic            iowN,
  output logic [7:0]      addr,
  output logic [7:0]      dataIn,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOeN
);
  // ****************************************
  // Idle bus
  // ****************************************
  initial
  begin
    csN    = 1'b1;
    iorN   = 1'b1;
    iowN   = 1'b1;
    addr   = 8'h00;
    dataIn = 8'h00;
  end

  // Read: strobe held until answer seen, bounded
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    #1;
    addr = a;
    csN  = 1'b0;
    iorN = 1'b0;
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(posedge clk);
      ok = (dataOeN === 1'b0);
      d  = dataOut;
    end
    #1;
    csN  = 1'b1;
    iorN = 1'b1;
    // Released pins show garbage, not the old address
    addr = ~a;
    // Spacing lets the output enable drop away
    repeat (4) @(posedge clk);
    // Hand back off the edge so callers never race the design
    #1;
  endtask : rd

  // Write: long strobe, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    addr   = a;
    dataIn = v;
    csN    = 1'b0;
    iowN   = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    csN    = 1'b1;
    iowN   = 1'b1;
    dataIn = ~v;
    repeat (3) @(posedge clk);
    #1;
  endtask : wr
endmodule : gisa_host_model

// >>> tb/gisa_asserts.sv
// Checker for the global interrupt source aggregator.
// Assumes one clock domain; bound to the top module ports.
`timescale 1ns/10ps
module gisa_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        csN,
  input wire logic        iorN,
  input wire logic [7:0]  addr,
  input wire logic        dataOeN,
  input wire logic [7:0]  chanReq,
  input wire logic [7:0]  chanIrqEnable,
  input wire logic [23:0] chanCode,
  input wire logic        timerTimeout,
  input wire logic        timerIrqEnable,
  input wire logic [7:0]  chanAsleep,
  input wire logic        wakeIrqEnable,
  input wire logic [7:0]  pendingMap,
  input wire logic [23:0] sourceCodes,
  input wire logic        timerPending,
  input wire logic        wakePending
);
  logic [7:0]  wantMap;    // Expected bits, channels 1..7
  logic [23:0] wantCodes;  // Expected codes, channels 1..7
  wire         own0 = chanReq[0] & chanIrqEnable[0];  // Channel 0 own request

  // Channel 0 left out: it also carries timer and wake
  always_comb
  begin
    wantMap   = 8'h00;
    wantCodes = 24'h00_0000;
    for (int n = 1; n < 8; n++)
    begin
      wantMap[n]          = chanReq[n] & chanIrqEnable[n] & (chanCode[3*n+:3] != 3'h7);
      wantCodes[3*n+:3]   = wantMap[n] ? chanCode[3*n+:3] : 3'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ****************************************
  // Properties
  // ****************************************
  sequence s_wakeEvt;
    chanAsleep == 8'hFF ##1 (chanAsleep != 8'hFF && wakeIrqEnable);
  endsequence

  property p_rst;
    $rose(rstn) |-> pendingMap == 8'h00 && sourceCodes == 24'h00_0000;
  endproperty
  property p_map;
    1'b1 |=> pendingMap[7:1] == $past(wantMap[7:1]);
  endproperty
  property p_codes;
    1'b1 |=> sourceCodes[23:3] == $past(wantCodes[23:3]);
  endproperty
  property p_ch0;
    own0 |=> pendingMap[0] && sourceCodes[2:0] == $past(chanCode[2:0]);
  endproperty
  property p_timer;
    timerTimeout && timerIrqEnable |=> timerPending;
  endproperty
  property p_noTimer;
    !timerPending && !(timerTimeout && timerIrqEnable) |=> !timerPending;
  endproperty
  property p_ch0T;
    timerPending && !own0 |=> pendingMap[0] && sourceCodes[2:0] == 3'h7;
  endproperty
  property p_wake;
    s_wakeEvt |=> wakePending;
  endproperty
  property p_oe;
    $fell(dataOeN) |-> !$past(iorN, 2) && !$past(csN, 2) && $past(addr, 2) inside {[8'h80:8'h83]};
  endproperty

  a_rst:     assert property (p_rst) else $error("registers not zero after reset");
  a_map:     assert property (p_map) else $error("pending map mismatch");
  a_codes:   assert property (p_codes) else $error("source codes mismatch");
  a_ch0:     assert property (p_ch0) else $error("channel 0 request lost");
  a_timer:   assert property (p_timer) else $error("timer flag not set");
  a_noTimer: assert property (p_noTimer) else $error("timer flag without event");
  a_ch0T:    assert property (p_ch0T) else $error("timer not on channel 0");
  a_wake:    assert property (p_wake) else $error("wake flag not set");
  a_oe:      assert property (p_oe) else $error("bus driven without read");
endmodule : gisa_asserts

bind global_interrupt_source_aggregator gisa_asserts chk_u (.clk, .rstn, .csN, .iorN, .addr,
  .dataOeN, .chanReq, .chanIrqEnable, .chanCode, .timerTimeout, .timerIrqEnable, .chanAsleep,
  .wakeIrqEnable, .pendingMap, .sourceCodes, .timerPending, .wakePending);

// >>> tb/global_interrupt_source_aggregator_test.sv
// Self-checking bench for the global interrupt source aggregator.
// Assumes the host model and checker compiled before it.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin numErrors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module global_interrupt_source_aggregator_test;
  logic clk, rstn, csN, iorN, iowN, dataOeN, timerTimeout, timerIrqEnable, wakeIrqEnable;
  logic [7:0]  addr, dataIn, dataOut, chanReq, chanIrqEnable, chanAsleep, pendingMap;
  logic [23:0] chanCode, sourceCodes;
  int          numErrors = 0;  // Mismatches
  int          checked   = 0;  // Comparisons

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  global_interrupt_source_aggregator dut_u (.clk, .rstn, .csN, .iorN, .iowN, .addr, .dataIn,
    .dataOut, .dataOeN, .chanReq, .chanIrqEnable, .chanCode, .timerTimeout, .timerIrqEnable,
    .chanAsleep, .wakeIrqEnable, .pendingMap, .sourceCodes, .timerPending(), .wakePending());
  gisa_host_model host_u (.clk, .csN, .iorN, .iowN, .addr, .dataIn, .dataOut, .dataOeN);

  // ****************************************
  // Helpers
  // ****************************************
  task end_sim;
    $display("errors %0d checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Step past an edge so inputs never race it
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task rdChk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit         ok;
    host_u.rd(a, d, ok);
    `CHK("answer", 1'b1, ok)
    if (!ok)
      end_sim();
    `CHK(nm, e, d)
  endtask : rdChk

  task rdNone(input logic [7:0] a);
    logic [7:0] d;
    bit         ok;
    host_u.rd(a, d, ok);
    `CHK("undriven", 1'b0, ok)
  endtask : rdNone

  task chkAll(input logic [7:0] m, input logic [23:0] c);
    rdChk("map", 8'h80, m);
    rdChk("low", 8'h81, c[7:0]);
    rdChk("mid", 8'h82, c[15:8]);
    rdChk("high", 8'h83, c[23:16]);
  endtask : chkAll

  // ****************************************
  // Scenarios
  // ****************************************
  task t_chan;
    logic [23:0] c;
    for (int n = 0; n < 8; n++)
      c[3*n+:3] = 3'(n % 4 + 1);
    chanCode      = c;
    chanReq       = 8'hFF;
    chanIrqEnable = 8'hFF;
    chkAll(8'hFF, c);
    // Disabled, reserved code and dropped request together
    chanIrqEnable[2] = 1'b0;
    chanCode[17:15]  = 3'h7;
    chanReq[6]       = 1'b0;
    c[8:6]           = 3'h0;
    c[20:15]         = 6'h00;
    chkAll(8'h9B, c);
    chanReq  = 8'h00;
    chanCode = 24'h00_0000;
  endtask : t_chan

  task t_timer;
    timerTimeout = 1'b1;
    step(1);
    timerTimeout = 1'b0;
    chkAll(8'h00, 24'h00_0000);
    timerIrqEnable = 1'b1;
    timerTimeout   = 1'b1;
    step(1);
    timerTimeout = 1'b0;
    chkAll(8'h01, 24'h00_0007);
    chkAll(8'h01, 24'h00_0007);
    rdNone(8'h84);
    chkAll(8'h00, 24'h00_0000);
  endtask : t_timer

  task t_wake;
    chanAsleep = 8'hFF;
    step(2);
    chanAsleep = 8'h00;
    chkAll(8'h00, 24'h00_0000);
    wakeIrqEnable = 1'b1;
    chanAsleep    = 8'h7F;
    step(2);
    chanAsleep = 8'h00;
    chkAll(8'h00, 24'h00_0000);
    chanAsleep = 8'hFF;
    step(2);
    chanAsleep = 8'h00;
    chkAll(8'h01, 24'h00_0000);
    rdNone(8'h02);
    chkAll(8'h00, 24'h00_0000);
  endtask : t_wake

  task t_write;
    host_u.wr(8'h80, 8'hFF);
    host_u.wr(8'h81, 8'hFF);
    chkAll(8'h00, 24'h00_0000);
    rdNone(8'h90);
  endtask : t_write

  // Mid-run reset must clear live map, codes and timer flag
  task t_reset;
    chanReq       = 8'hFF;
    chanIrqEnable = 8'hFF;
    chanCode      = 24'h24_9249;
    timerTimeout  = 1'b1;
    step(1);
    timerTimeout = 1'b0;
    step(2);
    `CHK("liveMap", 8'hFF, pendingMap)
    rstn    = 1'b0;
    chanReq = 8'h00;
    step(2);
    `CHK("rstMap", 8'h00, pendingMap)
    `CHK("rstCodes", 24'h00_0000, sourceCodes)
    rstn = 1'b1;
    chkAll(8'h00, 24'h00_0000);
  endtask : t_reset

  // Main sequence
  initial
  begin
    rstn           = 1'b0;
    chanReq        = 8'h00;
    chanIrqEnable  = 8'h00;
    chanCode       = 24'h00_0000;
    timerTimeout   = 1'b0;
    timerIrqEnable = 1'b0;
    chanAsleep     = 8'h00;
    wakeIrqEnable  = 1'b0;
    step(10);
    rstn = 1'b1;
    chkAll(8'h00, 24'h00_0000);
    t_chan();
    t_timer();
    t_wake();
    t_write();
    t_reset();
    end_sim();
  end
endmodule : global_interrupt_source_aggregator_test
